// file: src/tpw_pkg.sv
package tpw_pkg;
   // =====================================================
   // widths and counts
   localparam int unsigned TPW_CNT_W = 32;
   localparam int unsigned TPW_NUM_MATCH = 7;
   localparam int unsigned TPW_NUM_OUT = 6;
   localparam int unsigned TPW_IDX_W = 3;
   localparam int unsigned TPW_PERIOD_IDX = 0;
   localparam int unsigned TPW_CAP_NUM = 2;
   localparam int unsigned TPW_CAP_SEL_W = 1;
   // =====================================================
   // reset values
   localparam logic [31:0] TPW_CNT_RST = 32'h0000_0000;
   localparam logic [31:0] TPW_MATCH_RST = 32'h0000_0000;
   localparam logic [31:0] TPW_CNT_ONE = 32'h0000_0001;
   // =====================================================
   // counter run state
   typedef enum logic [1:0] {TPW_HALT, TPW_RUN, TPW_STOPPED} tpw_run_t;
endpackage

// file: src/tpw_match_mem.sv
`timescale 1ns/100ps
module tpw_match_mem #(
   parameter int unsigned W = tpw_pkg::TPW_CNT_W,
   parameter int unsigned N = tpw_pkg::TPW_NUM_MATCH,
   parameter int unsigned IW = tpw_pkg::TPW_IDX_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [IW-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   input wire logic [IW-1:0] rd_idx,
   output logic [W-1:0] rd_data_q,
   output logic [N*W-1:0] words
);
   logic [W-1:0] mem_q [N];

   // =====================================================
   // write port, out of range index is dropped
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < N; i++)
         begin
            mem_q[i] <= W'(tpw_pkg::TPW_MATCH_RST);
         end
      end
      else if (wr_en && (32'(wr_idx) < N))
      begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   // =====================================================
   // registered readback, unmapped index reads zero
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_q <= '0;
      end
      else if (32'(rd_idx) < N)
      begin
         rd_data_q <= mem_q[rd_idx];
      end
      else
      begin
         rd_data_q <= '0;
      end
   end

   // all words in parallel so the boundary copy needs no read slots
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_flat
         assign words[g*W +: W] = mem_q[g];
      end
   endgenerate
endmodule

// file: src/tpw_pwm_unit.sv
`timescale 1ns/100ps
// How it works
// R1: a 32-bit counter advances once per programmed prescaler span.
// R2: counts core clock ticks, or rising edges of a chosen capture pin.
// R3: seven match registers drive six single-edge outputs; outputs 1 to 5 may be double-edge instead.
// R4: each match may keep running, stop, or reset, with optional pending flag.
// R5: the period match resets the count and sets the common cycle.
// R6: a single-edge output falls on its own match register.
// R7: the single-edge fall register is separate from the period register.
// R8: single-edge outputs rise at each period match unless held constant low.
// R9: all single-edge rising edges coincide with the period match.
// R10: a double-edge output rises on one match and falls on the next.
// R11: each double-edge output uses only two further match registers.
// R12: either double-edge position may be any count of the cycle.
// R13: rise before fall gives a high pulse, fall first a low pulse.
// R14: period and widths are any whole number of counts.
// R15: all outputs repeat at the single period rate.
// R16: match values change only at cycle boundaries, never mid-cycle.
// R17: software releases new match values before they may take effect.
// R18: with pwm mode off the unit is a plain timer, outputs low.
// R19: released values copy into the active set at the next period match.
// R20: enabled match events set sticky flags cleared by writing a one.
module tpw_pwm_unit #(
   parameter int unsigned CNT_W = tpw_pkg::TPW_CNT_W,
   parameter int unsigned NUM_MATCH = tpw_pkg::TPW_NUM_MATCH,
   parameter int unsigned NUM_OUT = tpw_pkg::TPW_NUM_OUT,
   parameter int unsigned IDX_W = tpw_pkg::TPW_IDX_W,
   parameter int unsigned CAP_NUM = tpw_pkg::TPW_CAP_NUM,
   parameter int unsigned CAP_SEL_W = tpw_pkg::TPW_CAP_SEL_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic run_enable,
   input wire logic counter_mode,
   input wire logic [CAP_SEL_W-1:0] cap_sel,
   input wire logic [CAP_NUM-1:0] cap_in,
   input wire logic [CNT_W-1:0] prescale_max,
   input wire logic pwm_enable,
   input wire logic [NUM_OUT-1:0] out_enable,
   input wire logic [NUM_OUT-1:0] double_sel,
   input wire logic [NUM_MATCH-1:0] match_int_en,
   input wire logic [NUM_MATCH-1:0] match_reset_en,
   input wire logic [NUM_MATCH-1:0] match_stop_en,
   input wire logic match_wr_en,
   input wire logic [IDX_W-1:0] match_wr_idx,
   input wire logic [CNT_W-1:0] match_wr_data,
   input wire logic [NUM_MATCH-1:0] match_release,
   input wire logic [IDX_W-1:0] match_rd_idx,
   output logic [CNT_W-1:0] match_rd_data,
   input wire logic [NUM_MATCH-1:0] irq_clear,
   output logic [NUM_MATCH-1:0] irq_pending,
   output logic [NUM_MATCH-1:0] release_pending,
   output logic [CNT_W-1:0] count_value,
   output logic [CNT_W-1:0] prescale_value,
   output logic running,
   output logic [NUM_OUT-1:0] pwm_out
);
   localparam int unsigned PER = tpw_pkg::TPW_PERIOD_IDX;
   localparam logic [CNT_W-1:0] ONE = CNT_W'(tpw_pkg::TPW_CNT_ONE);

   function automatic logic tpw_hit(input logic t,
                                    input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] v);
      return t && (c == v);
   endfunction

   function automatic logic [CNT_W-1:0] tpw_inc(input logic [CNT_W-1:0] c);
      return c + ONE;
   endfunction

   logic [CAP_NUM-1:0] cap_s1_q;
   logic [CAP_NUM-1:0] cap_s2_q;
   logic [CAP_NUM-1:0] cap_s3_q;
   logic cap_edge;
   logic cnt_src;
   logic active;
   logic tick;
   logic [CNT_W-1:0] pc_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] act_q [NUM_MATCH];
   logic [NUM_MATCH*CNT_W-1:0] shadow_flat;
   logic [NUM_MATCH-1:0] hit;
   logic [NUM_MATCH-1:0] rel_q;
   logic [NUM_MATCH-1:0] pend_q;
   logic [NUM_OUT-1:0] lvl_q;
   logic period_evt;
   logic any_reset;
   logic any_stop;
   tpw_pkg::tpw_run_t state_q;
   tpw_pkg::tpw_run_t state_d;
   logic running_q;

   // =====================================================
   // shadow match values, written by software at any time
   tpw_match_mem #(
      .W(CNT_W),
      .N(NUM_MATCH),
      .IW(IDX_W)
   ) u_mem (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(match_wr_en),
      .wr_idx(match_wr_idx),
      .wr_data(match_wr_data),
      .rd_idx(match_rd_idx),
      .rd_data_q(match_rd_data),
      .words(shadow_flat)
   );

   // =====================================================
   // capture pin synchroniser, third stage only for edge detect
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cap_s1_q <= '0;
         cap_s2_q <= '0;
         cap_s3_q <= '0;
      end
      else
      begin
         cap_s1_q <= cap_in;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
      end
   end

   assign cap_edge = cap_s2_q[cap_sel] & ~cap_s3_q[cap_sel];
   assign cnt_src = counter_mode ? cap_edge : 1'b1; // R2
   assign active = (state_q == tpw_pkg::TPW_RUN);
   assign tick = active && cnt_src && (pc_q == prescale_max); // R1

   // =====================================================
   // match detection on the active (not shadow) values
   always_comb
   begin
      for (int i = 0; i < NUM_MATCH; i++)
      begin
         hit[i] = tpw_hit(tick, count_q, act_q[i]); // R3 R14
      end
   end

   // pwm mode forces the period register to reset the count
   assign period_evt = hit[PER] && (pwm_enable || match_reset_en[PER]); // R5
   assign any_reset = period_evt || (|(hit & match_reset_en)); // R4
   assign any_stop = |(hit & match_stop_en); // R4

   // =====================================================
   // prescaler and counter
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pc_q <= CNT_W'(tpw_pkg::TPW_CNT_RST);
      end
      else if (!active)
      begin
         pc_q <= CNT_W'(tpw_pkg::TPW_CNT_RST);
      end
      else if (cnt_src)
      begin
         pc_q <= tick ? CNT_W'(tpw_pkg::TPW_CNT_RST) : tpw_inc(pc_q); // R1
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= CNT_W'(tpw_pkg::TPW_CNT_RST);
      end
      else if (tick)
      begin
         // a reset match wins over the increment; a stop match still increments, then holds
         count_q <= any_reset ? CNT_W'(tpw_pkg::TPW_CNT_RST)
                              : tpw_inc(count_q); // R4 R5 R15
      end
   end

   // =====================================================
   // run state: halted while disabled, parked after a stop match
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         tpw_pkg::TPW_HALT:
            if (run_enable) state_d = tpw_pkg::TPW_RUN;
         tpw_pkg::TPW_RUN:
            if (!run_enable) state_d = tpw_pkg::TPW_HALT;
            else if (any_stop) state_d = tpw_pkg::TPW_STOPPED; // R4
         tpw_pkg::TPW_STOPPED:
            if (!run_enable) state_d = tpw_pkg::TPW_HALT;
         default:
            state_d = tpw_pkg::TPW_HALT;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= tpw_pkg::TPW_HALT;
         running_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         running_q <= (state_d == tpw_pkg::TPW_RUN);
      end
   end

   // =====================================================
   // release latch: a release in the copy cycle stays pending
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rel_q <= '0;
      end
      else if (!pwm_enable)
      begin
         rel_q <= '0;
      end
      else
      begin
         rel_q <= match_release | (rel_q & ~{NUM_MATCH{period_evt}}); // R17
      end
   end

   // =====================================================
   // active values; timer mode tracks the shadow directly
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_MATCH; i++)
         begin
            act_q[i] <= CNT_W'(tpw_pkg::TPW_MATCH_RST);
         end
      end
      else
      begin
         for (int i = 0; i < NUM_MATCH; i++)
         begin
            if (!pwm_enable)
            begin
               act_q[i] <= shadow_flat[i*CNT_W +: CNT_W]; // R18
            end
            else if (period_evt && rel_q[i])
            begin
               act_q[i] <= shadow_flat[i*CNT_W +: CNT_W]; // R16 R19
            end
         end
      end
   end

   // =====================================================
   // sticky match flags, a new event beats a clear
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pend_q <= '0;
      end
      else
      begin
         pend_q <= (pend_q & ~irq_clear) | (hit & match_int_en); // R4 R20
      end
   end

   // =====================================================
   // waveform; output n uses match n+1, double edge also match n
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         lvl_q <= '0;
      end
      else
      begin
         for (int n = 0; n < NUM_OUT; n++)
         begin
            if (!pwm_enable || !out_enable[n])
            begin
               lvl_q[n] <= 1'b0; // R18
            end
            else if (double_sel[n] && (n > 0))
            begin
               // fall wins if both edges land on the same count
               if (hit[n+1])
               begin
                  lvl_q[n] <= 1'b0; // R10 R11 R12 R13
               end
               else if (hit[n])
               begin
                  lvl_q[n] <= 1'b1; // R10 R12 R13
               end
            end
            else if (hit[n+1])
            begin
               lvl_q[n] <= 1'b0; // R6 R7
            end
            else if (period_evt && (act_q[n+1] != '0))
            begin
               // a zero fall position would give a one-count glitch
               lvl_q[n] <= 1'b1; // R8 R9 R15
            end
         end
      end
   end

   assign pwm_out = lvl_q;
   assign irq_pending = pend_q;
   assign release_pending = rel_q;
   assign count_value = count_q;
   assign prescale_value = pc_q;
   assign running = running_q;

   // =====================================================
   // checks
   property p_presc_step;
      @(posedge core_clk) disable iff (rst)
      (tick && !any_reset) |=> (pc_q == '0) &&
         (count_q == tpw_inc($past(count_q)));
   endproperty
   a_presc_step: assert property (p_presc_step) // R1
      else $error("count did not advance on prescaler wrap");

   property p_presc_hold;
      @(posedge core_clk) disable iff (rst)
      (active && !tick) |=> $stable(count_q);
   endproperty
   a_presc_hold: assert property (p_presc_hold) // R1
      else $error("count moved between prescaler wraps");

   property p_cnt_src;
      @(posedge core_clk) disable iff (rst)
      (active && counter_mode && !cap_edge) |=> $stable(pc_q);
   endproperty
   a_cnt_src: assert property (p_cnt_src) // R2
      else $error("prescaler moved without a capture edge");

   property p_period_reset;
      @(posedge core_clk) disable iff (rst)
      period_evt |=> (count_q == '0);
   endproperty
   a_period_reset: assert property (p_period_reset) // R5
      else $error("period match did not clear the count");

   property p_stop;
      @(posedge core_clk) disable iff (rst)
      (any_stop && run_enable) |=> (state_q == tpw_pkg::TPW_STOPPED)
         ##1 $stable(count_q);
   endproperty
   a_stop: assert property (p_stop) // R4
      else $error("stop match did not freeze the counter");

   property p_single_rise;
      @(posedge core_clk) disable iff (rst)
      (period_evt && pwm_enable && out_enable[0] && !hit[1] &&
         (act_q[1] != '0)) |=> pwm_out[0];
   endproperty
   a_single_rise: assert property (p_single_rise) // R8
      else $error("single edge output did not rise at period match");

   property p_single_fall;
      @(posedge core_clk) disable iff (rst)
      (hit[1] && pwm_enable) |=> !pwm_out[0];
   endproperty
   a_single_fall: assert property (p_single_fall) // R6
      else $error("single edge output did not fall on its match");

   property p_double_edges;
      @(posedge core_clk) disable iff (rst)
      (pwm_enable && out_enable[2] && double_sel[2] && hit[2] && !hit[3])
         |=> pwm_out[2];
   endproperty
   a_double_edges: assert property (p_double_edges) // R10
      else $error("double edge output missed its rising match");

   property p_hold_midcycle;
      @(posedge core_clk) disable iff (rst)
      (pwm_enable && !period_evt) |=> $stable(act_q[1]);
   endproperty
   a_hold_midcycle: assert property (p_hold_midcycle) // R16
      else $error("active match value changed inside a cycle");

   property p_release_copy;
      @(posedge core_clk) disable iff (rst)
      (pwm_enable && period_evt && rel_q[1]) |=>
         (act_q[1] == $past(shadow_flat[CNT_W +: CNT_W]));
   endproperty
   a_release_copy: assert property (p_release_copy) // R19
      else $error("released value not copied at period match");

   property p_timer_mode;
      @(posedge core_clk) disable iff (rst)
      !pwm_enable |=> (pwm_out == '0);
   endproperty
   a_timer_mode: assert property (p_timer_mode) // R18
      else $error("waveform driven with pwm mode off");

   property p_sticky;
      @(posedge core_clk) disable iff (rst)
      (irq_pending[1] && !irq_clear[1]) |=> irq_pending[1];
   endproperty
   a_sticky: assert property (p_sticky) // R20
      else $error("pending flag dropped without a clear");
endmodule

// file: test/tpw_load_model.sv
`timescale 1ns/100ps
// =====================================================
// load stage: integrates the on-time of each drive line
// a plain integrator, because a real load cannot see single
// edges, only the energy delivered over whole periods
module tpw_load_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic [5:0] drive,
   output logic [95:0] on_cycles
);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         on_cycles <= '0;
      else if (clear)
         on_cycles <= '0;
      else
         for (int i = 0; i < 6; i++)
            on_cycles[i*16 +: 16] <= on_cycles[i*16 +: 16] + 16'(drive[i]);
   end
endmodule

// file: test/test_timer_based_pwm_unit.sv
`timescale 1ns/100ps
module test_timer_based_pwm_unit;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic run_enable = 1'b0;
   logic counter_mode = 1'b0;
   logic [0:0] cap_sel = 1'h0;
   logic [1:0] cap_in = 2'h0;
   logic [31:0] prescale_max = 32'h0000_0000;
   logic pwm_enable = 1'b1;
   logic [5:0] out_enable = 6'h00;
   logic [5:0] double_sel = 6'h00;
   logic [6:0] match_int_en = 7'h00;
   logic [6:0] match_reset_en = 7'h00;
   logic [6:0] match_stop_en = 7'h00;
   logic match_wr_en = 1'b0;
   logic [2:0] match_wr_idx = 3'h0;
   logic [31:0] match_wr_data = 32'h0000_0000;
   logic [6:0] match_release = 7'h00;
   logic [2:0] match_rd_idx = 3'h0;
   logic [6:0] irq_clear = 7'h00;
   logic load_clear = 1'b0;
   logic [31:0] match_rd_data, count_value, prescale_value;
   logic [6:0] irq_pending, release_pending;
   logic running;
   logic [5:0] pwm_out;
   logic [95:0] on_cycles;
   logic [31:0] v, m;
   logic [31:0] mv [7] = '{32'h0000_0009, 32'h0000_0003, 32'h0000_0006,
      32'h0000_0008, 32'h0000_0002, 32'h0000_0000, 32'h0000_0005};
   logic [31:0] ex [6] = '{32'h0000_0014, 32'h0000_0023, 32'h0000_000a,
      32'h0000_0014, 32'h0000_0000, 32'h0000_0000};
   int bad_count = 0;
   int comparisons = 0;

   always #4 core_clk = ~core_clk;

   tpw_pwm_unit dut_u (.core_clk(core_clk), .rst(rst),
      .run_enable(run_enable), .counter_mode(counter_mode),
      .cap_sel(cap_sel), .cap_in(cap_in), .prescale_max(prescale_max),
      .pwm_enable(pwm_enable), .out_enable(out_enable),
      .double_sel(double_sel), .match_int_en(match_int_en),
      .match_reset_en(match_reset_en), .match_stop_en(match_stop_en),
      .match_wr_en(match_wr_en), .match_wr_idx(match_wr_idx),
      .match_wr_data(match_wr_data), .match_release(match_release),
      .match_rd_idx(match_rd_idx), .match_rd_data(match_rd_data),
      .irq_clear(irq_clear), .irq_pending(irq_pending),
      .release_pending(release_pending), .count_value(count_value),
      .prescale_value(prescale_value), .running(running),
      .pwm_out(pwm_out));

   tpw_load_model load_u (.core_clk(core_clk), .rst(rst),
      .clear(load_clear), .drive(pwm_out), .on_cycles(on_cycles));

   // =====================================================
   // access tasks
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_match(input int idx, input logic [31:0] d);
      @(posedge core_clk);
      match_wr_en <= 1'b1;
      match_wr_idx <= 3'(idx);
      match_wr_data <= d;
      @(posedge core_clk);
      match_wr_en <= 1'b0;
   endtask

   task automatic rd_match(input int idx, output logic [31:0] d);
      @(posedge core_clk);
      match_rd_idx <= 3'(idx);
      step(2);
      #1;
      d = match_rd_data;
   endtask

   task automatic pulse_release(input logic [6:0] mask);
      @(posedge core_clk);
      match_release <= mask;
      @(posedge core_clk);
      match_release <= 7'h00;
      #1;
   endtask

   function automatic logic [31:0] on_time(input int i);
      return 32'(on_cycles[i*16 +: 16]);
   endfunction

   // measures n cycles; out0/out1 rises must meet a zero count
   task automatic window(input int n, output logic [31:0] maxc);
      logic [5:0] prev;
      maxc = '0;
      @(posedge core_clk);
      load_clear <= 1'b1;
      @(posedge core_clk);
      load_clear <= 1'b0;
      #1;
      prev = pwm_out;
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         if (count_value > maxc)
            maxc = count_value;
         for (int i = 0; i < 2; i++)
            if (pwm_out[i] && !prev[i])
               chk(count_value, 32'h0000_0000);
         prev = pwm_out;
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // =====================================================
   // main sequence
   initial
   begin
      step(4);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(count_value, 32'h0000_0000);
      chk(32'(pwm_out), 32'h0000_0000);
      for (int i = 0; i < 8; i++)
         wr_match(i, 32'h0000_1000 + 32'(i));
      for (int i = 0; i < 8; i++)
      begin
         rd_match(i, v);
         chk(v, (i < 7) ? 32'h0000_1000 + 32'(i) : 32'h0000_0000);
      end
      // out0/out1 single, out2 high pulse, out3 low pulse, out4 held low
      for (int i = 0; i < 7; i++)
         wr_match(i, mv[i]);
      pulse_release(7'h7f);
      chk(32'(release_pending), 32'h0000_007f);
      out_enable <= 6'h1f;
      double_sel <= 6'h0c;
      run_enable <= 1'b1;
      step(30);
      #1;
      chk(32'(release_pending), 32'h0000_0000);
      chk(32'(running), 32'h0000_0001);
      window(50, m);
      chk(m, 32'h0000_0009);
      for (int i = 0; i < 6; i++)
         chk(on_time(i), ex[i]);
      // unreleased value must not disturb the running cycle
      wr_match(1, 32'h0000_0005);
      window(50, m);
      chk(on_time(0), 32'h0000_0014);
      pulse_release(7'h02);
      chk(32'(release_pending), 32'h0000_0002);
      step(12);
      window(50, m);
      chk(on_time(0), 32'h0000_001e);
      chk(on_time(1), 32'h0000_0023);
      // pending flag is sticky until a one is written
      match_int_en <= 7'h02;
      step(12);
      #1;
      chk(32'(irq_pending), 32'h0000_0002);
      match_int_en <= 7'h00;
      step(2);
      irq_clear <= 7'h02;
      @(posedge core_clk);
      irq_clear <= 7'h00;
      step(2);
      #1;
      chk(32'(irq_pending), 32'h0000_0000);
      // plain timer: match1 resets the count, no waveform
      pwm_enable <= 1'b0;
      match_reset_en <= 7'h03;
      step(12);
      window(60, m);
      chk(m, 32'h0000_0005);
      chk(32'(|on_cycles), 32'h0000_0000);
      // stop on match2 freezes the count
      match_reset_en <= 7'h00;
      match_stop_en <= 7'h04;
      step(12);
      #1;
      chk(32'(running), 32'h0000_0000);
      v = count_value;
      step(5);
      #1;
      chk(count_value, v);
      // prescaler of four source ticks per count
      run_enable <= 1'b0;
      match_stop_en <= 7'h00;
      prescale_max <= 32'h0000_0003;
      step(2);
      #1;
      chk(prescale_value, 32'h0000_0000);
      run_enable <= 1'b1;
      step(4);
      #1;
      v = count_value;
      step(40);
      #1;
      chk(count_value - v, 32'h0000_000a);
      // counter mode: only edges of the selected pin count
      // halt first so the prescaler restarts at zero, its new terminal value
      run_enable <= 1'b0;
      counter_mode <= 1'b1;
      cap_sel <= 1'h1;
      prescale_max <= 32'h0000_0000;
      step(2);
      run_enable <= 1'b1;
      step(6);
      #1;
      v = count_value;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge core_clk);
         cap_in <= 2'h1;
         step(3);
         cap_in <= 2'h2;
         step(3);
      end
      cap_in <= 2'h0;
      step(8);
      #1;
      chk(count_value - v, 32'h0000_0005);
      finish_test();
   end
endmodule
